/* File: kp_data_bank.sv */
// keypad result, dac, gpio data and adc resolution registers behind the host serial link
`timescale 1ns/1ps
`default_nettype none

module kp_data_bank
    import kp_regs_pkg::*;
#(
    parameter int unsigned CYC_PER_BIT = 4          // core cycles per converted bit
) (
    input  wire logic        core_clk,      // 50 MHz core clock
    input  wire logic        nrst,          // async reset, active low
    input  wire logic        sclk,          // host serial clock
    input  wire logic        cs_n,          // host chip select, active low
    input  wire logic        din,           // host serial data in
    output var  logic        dout,          // serial data out
    output var  logic        dout_oe_n,     // dout drive enable, low drives
    input  wire logic [7:0]  pin_in,        // row1..4, col1..4 pin levels
    output var  logic [7:0]  pin_out,       // pin output levels
    output var  logic [7:0]  pin_oe_n,      // pin drive enables, low drives
    input  wire logic [15:0] key_state,     // pressed keys from the scanner
    input  wire logic        key_scan_done, // scanner result valid, one cycle
    input  wire logic [11:0] adc_sample,    // full-scale converter code
    output var  logic [7:0]  dac_code,      // dac input code
    output var  logic        adc_busy,      // conversion in progress
    output var  logic        adc_done       // conversion finished, one cycle
);

    // ==========================================================================
    // checks and helpers
    // ==========================================================================
    if (CYC_PER_BIT < 1 || CYC_PER_BIT > 4096) begin : g_chk
        $error("CYC_PER_BIT must be 1..4096");
    end

    // column mask bits spread over the four keys of each column
    function automatic logic [15:0] col_expand(input logic [3:0] cm);
        logic [15:0] m;
        m = 16'h0000;
        for (int c = 0; c < 4; c++) begin
            m[4*c +: 4] = {4{cm[c]}};
        end
        return m;
    endfunction

    function automatic logic [3:0] res_bits(input logic [1:0] r);
        logic [3:0] b;
        b = (r == RES_8) ? BITS_8 : (r == RES_10) ? BITS_10 : BITS_12;
        return b;
    endfunction

    function automatic logic [7:0] out_mask(input logic [15:0] ctl);
        return ctl[PIN_SEL_LSB +: 8] & ctl[7:0];
    endfunction

    // ==========================================================================
    // synchronisers
    // ==========================================================================
    logic [2:0] sclk_sy_q;
    logic [1:0] cs_sy_q;
    logic [1:0] din_sy_q;
    logic [7:0] pin_m_q;
    logic [7:0] pin_s_q;

    // pins and host lines come from outside the core clock domain
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_sy_q <= 3'h0;
            cs_sy_q   <= 2'h3;
            din_sy_q  <= 2'h0;
            pin_m_q   <= RST_BYTE;
            pin_s_q   <= RST_BYTE;
        end else begin
            sclk_sy_q <= {sclk_sy_q[1:0], sclk};
            cs_sy_q   <= {cs_sy_q[0], cs_n};
            din_sy_q  <= {din_sy_q[0], din};
            pin_m_q   <= pin_in;
            pin_s_q   <= pin_m_q;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_s;
    logic din_s;
    assign sclk_rise = sclk_sy_q[1] & ~sclk_sy_q[2];
    assign sclk_fall = ~sclk_sy_q[1] & sclk_sy_q[2];
    assign cs_s      = cs_sy_q[1];
    assign din_s     = din_sy_q[1];

    // ==========================================================================
    // register state declarations
    // ==========================================================================
    logic [7:0]  dac_q, dac_d;
    logic [7:0]  gpd_q, gpd_d;
    logic [15:0] gpctl_q, gpctl_d;
    logic [15:0] kmask_q, kmask_d;
    logic [3:0]  cmask_q, cmask_d;
    logic [1:0]  res_q, res_d;
    logic [3:0]  csel_q, csel_d;
    logic [15:0] raw_q, raw_d;
    logic [15:0] pend_q, pend_d;
    logic [15:0] stat_q, stat_d;
    logic [7:0]  pin_oe_n_q, pin_oe_n_d;
    logic        ref_on_q, ref_on_d;
    logic [10:0] ref_cnt_q, ref_cnt_d;
    logic [11:0] result_q, result_d;

    // ==========================================================================
    // serial link
    // ==========================================================================
    link_state_t lk_q, lk_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [15:0] rx_q, rx_d;
    logic [15:0] cmd_q, cmd_d;
    logic [15:0] tx_q, tx_d;
    logic        dout_q, dout_d;
    logic        doe_n_q, doe_n_d;
    logic        wr_stb, rd_stb;
    logic [15:0] word_in;
    logic [15:0] rd_word;
    logic [ADDR_W-1:0] wr_addr;

    assign word_in = {rx_q[14:0], din_s};
    assign wr_addr = cmd_q[ADDR_W-1:0];

    // read data for the command just completing; reserved bits are zero
    always_comb begin
        unique case (word_in[ADDR_W-1:0])
            A_KEY_RAW:  rd_word = raw_q;
            A_KEY_PEND: rd_word = pend_q;
            A_KEY_STAT: rd_word = stat_q;
            A_CONV_RES: rd_word = {4'h0, result_q};
            A_DAC:      rd_word = {8'h00, dac_q};
            A_PIN_DATA: rd_word = {pin_s_q, 8'h00};
            A_PIN_CTL:  rd_word = gpctl_q;
            A_KEY_MASK: rd_word = kmask_q;
            A_COL_MASK: rd_word = {cmask_q, 12'h000};
            A_ADC_CTL:  rd_word = {2'h0, csel_q, res_q, 6'h00, adc_busy, ref_on_q};
            default:    rd_word = RST_WORD;
        endcase
    end

    // 16 command bits then 16 data bits, msb first, host samples on rising sclk
    always_comb begin
        lk_d    = lk_q;
        cnt_d   = cnt_q;
        rx_d    = rx_q;
        cmd_d   = cmd_q;
        tx_d    = tx_q;
        dout_d  = dout_q;
        doe_n_d = doe_n_q;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
        if (cs_s) begin
            lk_d    = LK_IDLE;
            cnt_d   = 5'h00;
            doe_n_d = 1'b1;
        end else begin
            unique case (lk_q)
                LK_IDLE: begin
                    lk_d  = LK_CMD;
                    cnt_d = 5'h00;
                end
                LK_CMD: begin
                    if (sclk_rise) begin
                        rx_d  = word_in;
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == LAST_BIT) begin
                            cmd_d   = word_in;
                            rd_stb  = word_in[CMD_RD_BIT];
                            tx_d    = rd_word;
                            doe_n_d = ~word_in[CMD_RD_BIT];
                            cnt_d   = 5'h00;
                            lk_d    = LK_DATA;
                        end
                    end
                end
                LK_DATA: begin
                    if (sclk_fall && cmd_q[CMD_RD_BIT]) begin
                        dout_d = tx_q[15];
                        tx_d   = {tx_q[14:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        rx_d  = word_in;
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == LAST_BIT) begin
                            wr_stb  = ~cmd_q[CMD_RD_BIT];
                            cnt_d   = 5'h00;
                            doe_n_d = 1'b1;
                            lk_d    = LK_CMD;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lk_q    <= LK_IDLE;
            cnt_q   <= 5'h00;
            rx_q    <= RST_WORD;
            cmd_q   <= RST_WORD;
            tx_q    <= RST_WORD;
            dout_q  <= 1'b0;
            doe_n_q <= 1'b1;
        end else begin
            lk_q    <= lk_d;
            cnt_q   <= cnt_d;
            rx_q    <= rx_d;
            cmd_q   <= cmd_d;
            tx_q    <= tx_d;
            dout_q  <= dout_d;
            doe_n_q <= doe_n_d;
        end
    end

    // ==========================================================================
    // registers, keypad results and pins
    // ==========================================================================
    logic [15:0] col_blk;
    logic [15:0] key_blk;
    logic        conv_start;
    assign col_blk = col_expand(cmask_q);
    assign key_blk = col_blk | kmask_q;

    // result registers have no write decode, so host writes to them vanish
    always_comb begin
        dac_d   = dac_q;
        gpd_d   = gpd_q;
        gpctl_d = gpctl_q;
        kmask_d = kmask_q;
        cmask_d = cmask_q;
        res_d   = res_q;
        csel_d  = csel_q;
        raw_d   = raw_q;
        stat_d  = stat_q;
        conv_start = 1'b0;
        // pending clears on its own read, but a scan in the same cycle wins
        pend_d  = (rd_stb && word_in[ADDR_W-1:0] == A_KEY_PEND) ? RST_WORD : pend_q;
        if (wr_stb) begin
            unique case (wr_addr)
                A_DAC:      dac_d   = word_in[7:0];
                A_PIN_DATA: gpd_d   = word_in[PIN_DATA_LSB +: 8];
                A_PIN_CTL:  gpctl_d = word_in;
                A_KEY_MASK: kmask_d = word_in;
                A_COL_MASK: cmask_d = word_in[COL_MASK_LSB +: 4];
                A_ADC_CTL: begin
                    csel_d = word_in[CSEL_LSB +: 4];
                    if (word_in[CSEL_LSB +: 4] != 4'h0) begin
                        res_d      = word_in[RES_LSB +: 2];
                        conv_start = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        gpd_d = gpd_d & out_mask(gpctl_d);
        if (key_scan_done) begin
            raw_d  = key_state & ~col_blk;
            pend_d = pend_d | (key_state & ~col_blk);
            stat_d = (stat_q & key_blk) | (key_state & ~key_blk);
        end
        pin_oe_n_d = ~out_mask(gpctl_d);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dac_q      <= RST_BYTE;
            gpd_q      <= RST_BYTE;
            gpctl_q    <= RST_WORD;
            kmask_q    <= RST_WORD;
            cmask_q    <= 4'h0;
            res_q      <= RES_8;
            csel_q     <= 4'h0;
            raw_q      <= RST_WORD;
            pend_q     <= RST_WORD;
            stat_q     <= RST_WORD;
            pin_oe_n_q <= 8'hff;
        end else begin
            dac_q      <= dac_d;
            gpd_q      <= gpd_d;
            gpctl_q    <= gpctl_d;
            kmask_q    <= kmask_d;
            cmask_q    <= cmask_d;
            res_q      <= res_d;
            csel_q     <= csel_d;
            raw_q      <= raw_d;
            pend_q     <= pend_d;
            stat_q     <= stat_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    // ==========================================================================
    // reference power and conversion timing
    // ==========================================================================
    conv_state_t cv_q, cv_d;
    logic [15:0] cv_cnt_q, cv_cnt_d;
    logic [11:0] smp_q, smp_d;
    logic [3:0]  cv_bits_q, cv_bits_d;
    logic        busy_q, busy_d;
    logic        done_q, done_d;
    logic        ref_wr;

    assign ref_wr = wr_stb && wr_addr == A_ADC_CTL && word_in[CSEL_LSB +: 4] == 4'h0;

    // a conversion takes bits*CYC_PER_BIT cycles, so low resolution is quicker
    always_comb begin
        cv_d      = cv_q;
        cv_cnt_d  = cv_cnt_q;
        smp_d     = smp_q;
        cv_bits_d = cv_bits_q;
        result_d  = result_q;
        busy_d    = busy_q;
        done_d    = 1'b0;
        ref_on_d  = ref_on_q;
        ref_cnt_d = (ref_cnt_q != 11'h000) ? ref_cnt_q - 11'h001 : ref_cnt_q;
        if (ref_cnt_q == 11'h001) begin
            ref_on_d = 1'b1;
        end
        if (ref_wr) begin
            ref_on_d  = (word_in[RES_LSB +: 2] == RES_10);
            ref_cnt_d = (word_in[RES_LSB +: 2] == RES_8) ? REF_UP_CNT : 11'h000;
        end
        unique case (cv_q)
            CV_IDLE: begin
                if (conv_start) begin
                    cv_bits_d = res_bits(res_d);
                    cv_cnt_d  = 16'(res_bits(res_d) * CYC_PER_BIT - 1);
                    smp_d     = adc_sample;
                    busy_d    = 1'b1;
                    cv_d      = CV_RUN;
                end
            end
            CV_RUN: begin
                cv_cnt_d = cv_cnt_q - 16'h0001;
                if (cv_cnt_q == 16'h0000) begin
                    result_d = smp_q >> (BITS_12 - cv_bits_q);
                    busy_d   = 1'b0;
                    done_d   = 1'b1;
                    cv_d     = CV_DONE;
                end
            end
            CV_DONE: cv_d = CV_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cv_q      <= CV_IDLE;
            cv_cnt_q  <= 16'h0000;
            smp_q     <= 12'h000;
            cv_bits_q <= BITS_8;
            result_q  <= 12'h000;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            ref_on_q  <= 1'b0;
            ref_cnt_q <= REF_UP_CNT;
        end else begin
            cv_q      <= cv_d;
            cv_cnt_q  <= cv_cnt_d;
            smp_q     <= smp_d;
            cv_bits_q <= cv_bits_d;
            result_q  <= result_d;
            busy_q    <= busy_d;
            done_q    <= done_d;
            ref_on_q  <= ref_on_d;
            ref_cnt_q <= ref_cnt_d;
        end
    end

    assign dout      = dout_q;
    assign dout_oe_n = doe_n_q;
    assign pin_out   = gpd_q;
    assign pin_oe_n  = pin_oe_n_q;
    assign dac_code  = dac_q;
    assign adc_busy  = busy_q;
    assign adc_done  = done_q;

    // ==========================================================================
    // assertions
    // ==========================================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic [15:0] busy_len_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy_len_q <= 16'h0000;
        end else begin
            busy_len_q <= busy_q ? busy_len_q + 16'h0001 : 16'h0000;
        end
    end

    sequence s_dac_write;
        wr_stb && wr_addr == A_DAC;
    endsequence
    sequence s_dac_seen;
        dac_code == $past(word_in[7:0]);
    endsequence

    a_raw_col_only: assert property (key_scan_done |=> (raw_q & $past(col_blk)) == 16'h0000 &&
                                     (raw_q | $past(col_blk)) == ($past(key_state) | $past(col_blk)))
        else $error("raw key result ignores column mask or obeys key mask");
    a_pend_col_block: assert property (1'b1 |=> ((pend_q & ~$past(pend_q)) & $past(col_blk)) == 16'h0000)
        else $error("pending bit set in a masked column");
    a_stat_key_block: assert property (1'b1 |=> ((stat_q ^ $past(stat_q)) & $past(key_blk)) == 16'h0000)
        else $error("masked status bit changed");
    a_dac_write_out: assert property (s_dac_write |=> s_dac_seen)
        else $error("dac code not taken from write");
    a_pin_data_zero: assert property ((word_in[ADDR_W-1:0] == A_PIN_DATA) |-> rd_word[7:0] == 8'h00)
        else $error("pin data reserved bits not zero");
    a_pin_discard: assert property ((pin_out & pin_oe_n) == 8'h00)
        else $error("pin data kept for a non-output pin");
    a_pin_drive: assert property (1'b1 |=> pin_oe_n == ~out_mask($past(gpctl_d)))
        else $error("pin drive enable does not follow select and enable");
    a_conv_length: assert property ($fell(busy_q) |-> busy_len_q == 16'(cv_bits_q * CYC_PER_BIT))
        else $error("conversion length does not match resolution");
    a_res_kept: assert property (ref_wr |=> res_q == $past(res_q) && !$rose(busy_q))
        else $error("reference write changed resolution or started a conversion");

endmodule
`default_nettype wire

/* File: kp_regs_pkg.sv */
// register map, field positions, reset values and timing constants of the keypad/gpio/dac data bank
`default_nettype none
package kp_regs_pkg;

    // ==========================================================================
    // serial command word
    // ==========================================================================
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned ADDR_W      = 7;
    localparam int unsigned CMD_RD_BIT  = 15;    // 1 = read, 0 = write
    localparam logic [4:0]  LAST_BIT    = 5'h0f; // bit count of the 16th bit

    // ==========================================================================
    // register offsets
    // ==========================================================================
    localparam logic [ADDR_W-1:0] A_KEY_RAW   = 7'h04;
    localparam logic [ADDR_W-1:0] A_CONV_RES  = 7'h07;
    localparam logic [ADDR_W-1:0] A_DAC       = 7'h0b;
    localparam logic [ADDR_W-1:0] A_PIN_DATA  = 7'h0f;
    localparam logic [ADDR_W-1:0] A_KEY_PEND  = 7'h10;
    localparam logic [ADDR_W-1:0] A_KEY_STAT  = 7'h11;
    localparam logic [ADDR_W-1:0] A_ADC_CTL   = 7'h40;
    localparam logic [ADDR_W-1:0] A_PIN_CTL   = 7'h4f;
    localparam logic [ADDR_W-1:0] A_KEY_MASK  = 7'h50;
    localparam logic [ADDR_W-1:0] A_COL_MASK  = 7'h51;

    // ==========================================================================
    // field positions
    // ==========================================================================
    localparam int unsigned PIN_DATA_LSB = 8;    // pin_data_field in [15:8]
    localparam int unsigned PIN_SEL_LSB  = 8;    // pin_repurpose_select in [15:8]
    localparam int unsigned COL_MASK_LSB = 12;   // column1..column4_mask in [15:12]
    localparam int unsigned CSEL_LSB     = 10;   // conversion_select_field in [13:10]
    localparam int unsigned RES_LSB      = 8;    // resolution_select_hi/lo in [9:8]
    localparam int unsigned BUSY_BIT     = 1;
    localparam int unsigned REF_ON_BIT   = 0;

    // resolution codes
    localparam logic [1:0] RES_8  = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [3:0] BITS_8  = 4'h8;
    localparam logic [3:0] BITS_10 = 4'ha;
    localparam logic [3:0] BITS_12 = 4'hc;

    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0]  RST_BYTE = 8'h00;

    // ==========================================================================
    // timing
    // ==========================================================================
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned REF_UP_NS     = 31000;  // reference power-up delay, 31 us
    localparam int unsigned REF_UP_CYC    = (REF_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] REF_UP_CNT    = 11'(REF_UP_CYC);

    typedef enum logic [1:0] {LK_IDLE = 2'b00, LK_CMD = 2'b01, LK_DATA = 2'b11} link_state_t;
    typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_RUN = 2'b01, CV_DONE = 2'b11} conv_state_t;

endpackage
`default_nettype wire

/* File: host_link_model.sv */
// host side model: drives the serial link as a mode-0 master
`timescale 1ns/1ps
`default_nettype none
module host_link_model #(
    parameter int HALF = 6        // core cycles per sclk half period
) (
    input  wire logic core_clk,   // pacing clock
    output var  logic sclk,       // serial clock, still between frames
    output var  logic cs_n,       // chip select, active low
    output var  logic din,        // data to the device
    input  wire logic dout        // data from the device
);
    // ==========================================================
    // idle link
    // ==========================================================
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // one frame: command word then data word, msb first
    task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd, output logic [15:0] rdat);
        logic [31:0] w;
        w = {cmd, wd};
        rdat = 16'h0000;
        @(posedge core_clk) cs_n <= 1'b0;
        repeat (HALF) @(posedge core_clk);
        for (int i = 31; i >= 0; i--) begin
            din <= w[i];
            repeat (HALF) @(posedge core_clk);
            sclk <= 1'b1;
            if (i < 16) rdat = {rdat[14:0], dout};
            repeat (HALF) @(posedge core_clk);
            sclk <= 1'b0;
        end
        cs_n <= 1'b1;
        din  <= ~din;   // released line never shows the last bit
        repeat (HALF) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the keypad, gpio and dac data bank
`timescale 1ns/1ps
`default_nettype none
`define chk(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module testbench;
    import kp_regs_pkg::*;
    localparam int CPB = 2;   // short conversion step keeps the run brief
    logic       core_clk, nrst, key_scan_done, dout, dout_oe_n, adc_busy, adc_done;
    logic [15:0] key_state, rx;
    logic [11:0] adc_sample;
    logic [7:0]  pin_ext, pin_out, pin_oe_n, pin_lvl, dac_code;
    wire logic   sclk, cs_n, din;
    logic        dout_line;
    // a released read line shows the inverse, so a late or missing drive enable breaks the read
    assign dout_line = dout_oe_n ? ~dout : dout;
    int error_cnt = 0, samples_checked = 0, cyc = 0, busy_n = 0;
    // pin wire level: driven pins win, others follow the outside world
    assign pin_lvl = (pin_out & ~pin_oe_n) | (pin_ext & pin_oe_n);
    kp_data_bank #(.CYC_PER_BIT(CPB)) i_kp_data_bank (.core_clk(core_clk), .nrst(nrst), .sclk(sclk),
        .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .pin_in(pin_lvl), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .key_state(key_state), .key_scan_done(key_scan_done), .adc_sample(adc_sample),
        .dac_code(dac_code), .adc_busy(adc_busy), .adc_done(adc_done));
    host_link_model i_host_link_model (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_line));
    // ==========================================================
    // clock, timeout and busy length
    // ==========================================================
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (adc_busy) busy_n <= busy_n + 1;
        if (cyc == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ==========================================================
    // register access over the serial link
    // ==========================================================
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        i_host_link_model.xfer({9'h000, a}, d, rx);
    endtask
    task automatic get(input logic [6:0] a);
        i_host_link_model.xfer({9'h100, a}, 16'h0000, rx);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [15:0] e);
        get(a);
        `chk(rx, e)
    endtask
    // start a conversion, check its length and its result
    task automatic conv(input logic [15:0] w, input int bits, input logic [15:0] e);
        @(posedge core_clk) busy_n <= 0;
        wr(A_ADC_CTL, w);
        for (int k = 0; k < 200 && adc_busy; k++) @(posedge core_clk);
        `chk(busy_n, bits * CPB)
        `chk(adc_done, 1'b1)
        rdc(A_CONV_RES, e);
    endtask
    // ==========================================================
    // tests
    // ==========================================================
    initial begin
        nrst = 1'b0;
        key_state = 16'h0000;
        key_scan_done = 1'b0;
        adc_sample = 12'habc;
        pin_ext = 8'h58;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        `chk(dac_code, 8'h00)
        get(A_ADC_CTL);
        `chk(rx[REF_ON_BIT], 1'b0)
        `chk(rx[RES_LSB +: 2], RES_8)
        wr(A_ADC_CTL, 16'h0100);
        `chk(adc_busy, 1'b0)
        get(A_ADC_CTL);
        `chk(rx[REF_ON_BIT], 1'b1)
        `chk(rx[RES_LSB +: 2], RES_8)
        wr(A_ADC_CTL, 16'h0200);
        get(A_ADC_CTL);
        `chk(rx[REF_ON_BIT], 1'b0)
        wr(A_ADC_CTL, 16'h0000);
        get(A_ADC_CTL);
        `chk(rx[REF_ON_BIT], 1'b0)
        repeat (1200) @(posedge core_clk);
        get(A_ADC_CTL);
        `chk(rx[REF_ON_BIT], 1'b1)
        $display("test reference done");
        wr(A_DAC, 16'hffa5);
        `chk(dac_code, 8'ha5)
        rdc(A_DAC, 16'h00a5);
        wr(A_KEY_RAW, 16'hffff);
        rdc(A_KEY_RAW, 16'h0000);
        $display("test dac done");
        wr(A_COL_MASK, 16'h8000);
        wr(A_KEY_MASK, 16'h0001);
        @(posedge core_clk);
        key_state <= 16'hffff;
        key_scan_done <= 1'b1;
        @(posedge core_clk);
        key_scan_done <= 1'b0;
        rdc(A_KEY_RAW, 16'h0fff);
        rdc(A_KEY_PEND, 16'h0fff);
        rdc(A_KEY_STAT, 16'h0ffe);
        rdc(A_KEY_PEND, 16'h0000);
        $display("test keypad done");
        wr(A_PIN_CTL, 16'h0f03);
        wr(A_PIN_DATA, 16'hffff);
        `chk(pin_out, 8'h03)
        `chk(pin_oe_n, 8'hfc)
        rdc(A_PIN_DATA, 16'h5b00);
        wr(A_PIN_CTL, 16'hffff);
        `chk(pin_out, 8'h03)
        $display("test gpio done");
        conv(16'h0400, 8, 16'h00ab);
        conv(16'h0500, 10, 16'h02af);
        conv(16'h0600, 12, 16'h0abc);
        $display("test adc done");
        give_verdict();
    end
endmodule
`default_nettype wire
